//--- nrc_pkg.sv
`default_nettype none
package nrc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_SEC_LOWER_BASE = 8'h70;
   localparam logic [7:0] OFS_SEC_UPPER_BASE = 8'h74;
   localparam logic [7:0] OFS_SEC_LOWER_LIMIT = 8'h78;
   localparam logic [7:0] OFS_SEC_UPPER_LIMIT = 8'h7C;
   localparam logic [7:0] OFS_CAP_STATUS = 8'h80;
   // Field positions
   localparam int LOWER_ADDR_LSB = 20;
   localparam int FREQ_LSB = 22;
   localparam int SPLIT_REQ_DELAYED_BIT = 21;
   localparam int SPLIT_CPL_OVERRUN_BIT = 20;
   localparam int UNEXPECTED_CPL_BIT = 19;
   localparam int CPL_DISCARDED_BIT = 18;
   localparam int CAP133_BIT = 17;
   localparam int D64_BIT = 16;
   // Fixed values and reset values
   localparam logic [7:0] CAPABILITY_ID = 8'h07;
   localparam logic [7:0] NEXT_CAP_PTR = 8'hA0;
   localparam logic [7:0] FIRST_CAP_PTR = 8'h80;
   localparam logic [11:0] FIRST_EXT_CAP_OFS = 12'h100;
   localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
   localparam logic [31:0] RESET_CAP_STATUS = 32'h0003_A007;
   localparam logic [19:0] LOW_BASE_FILL = 20'h0_0000;
   localparam logic [19:0] LOW_LIMIT_FILL = 20'hF_FFFF;
   // Secondary interface mode codes
   typedef enum logic [2:0] {
      FREQ_CONV = 3'b000,
      FREQ_66 = 3'b001,
      FREQ_100 = 3'b010,
      FREQ_133 = 3'b011
   } nrc_freq_e;
   // AHB transfer types
   localparam logic [1:0] HTRANS_IDLE = 2'b00;
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   // Secondary remap window
   typedef struct packed {
      logic [63:0] base;
      logic [63:0] limit;
   } nrc_window_s;
endpackage
`default_nettype wire

//--- nrc_regs.sv
`default_nettype none
module nrc_regs
   import nrc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [2:0] secondaryFreqMode,
   input wire logic unexpectedSplitCplEvent,
   input wire logic splitCplAbortEvent,
   output nrc_pkg::nrc_window_s secondaryWindow,
   output logic splitCplDiscard,
   output logic [7:0] capabilityPointer,
   output logic [11:0] firstExtCapOffset
);
   import nrc_pkg::*;

   // Bus phase state
   logic wrPend_q;
   logic [7:0] wrAddr_q;
   // Register storage and the values they take at the next edge
   logic [11:0] lowerBase_q;
   logic [11:0] lowerBase_d;
   logic [31:0] upperBase_q;
   logic [31:0] upperBase_d;
   logic [11:0] lowerLimit_q;
   logic [11:0] lowerLimit_d;
   logic [31:0] upperLimit_q;
   logic [31:0] upperLimit_d;
   logic unexpectedSplitCpl_q;
   logic unexpectedSplitCpl_d;
   logic splitCplDiscarded_q;
   logic splitCplDiscarded_d;
   // Synchronisers and edge memories of the pin inputs
   logic [2:0] freqSync1_q;
   logic [2:0] freqSync2_q;
   logic unexpSync1_q;
   logic unexpSync2_q;
   logic unexpPrev_q;
   logic abortSync1_q;
   logic abortSync2_q;
   logic abortPrev_q;
   // Output registers and combinational views
   logic [31:0] hrdata_q;
   logic discard_q;
   nrc_window_s window_q;
   logic addrPhase;
   logic unexpPulse;
   logic abortPulse;
   logic [31:0] capStatus;

   // True while the data phase of a write to the given offset is on the bus;
   // the slave never stalls, so that phase completes on the coming edge
   function automatic logic isWrite(input logic [7:0] ofs);
      return wrPend_q && (wrAddr_q == ofs);
   endfunction

   // Read view of any register offset; unmapped reads zero. It shows the
   // next register values, so a read whose address phase overlaps the data
   // phase of a write to the same register returns the new contents
   function automatic logic [31:0] readMux(input logic [7:0] ofs, input logic [31:0] capWord);
      logic [31:0] r;
      r = RESET_ZERO;
      case (ofs)
         OFS_SEC_LOWER_BASE: r = {lowerBase_d, LOW_BASE_FILL};
         OFS_SEC_UPPER_BASE: r = upperBase_d;
         OFS_SEC_LOWER_LIMIT: r = {lowerLimit_d, LOW_BASE_FILL};
         OFS_SEC_UPPER_LIMIT: r = upperLimit_d;
         OFS_CAP_STATUS: r = capWord;
         default: r = RESET_ZERO;
      endcase
      return r;
   endfunction

   // Valid address phase of this slave
   assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);

   // Capability and status word assembly; flags show their next value
   always_comb begin
      capStatus = RESET_ZERO;
      capStatus[7:0] = CAPABILITY_ID;
      capStatus[15:8] = NEXT_CAP_PTR;
      capStatus[D64_BIT] = RESET_CAP_STATUS[D64_BIT];
      capStatus[CAP133_BIT] = RESET_CAP_STATUS[CAP133_BIT];
      capStatus[CPL_DISCARDED_BIT] = splitCplDiscarded_d;
      capStatus[UNEXPECTED_CPL_BIT] = unexpectedSplitCpl_d;
      capStatus[SPLIT_CPL_OVERRUN_BIT] = 1'b0;
      capStatus[SPLIT_REQ_DELAYED_BIT] = 1'b0;
      capStatus[FREQ_LSB+2:FREQ_LSB] = freqSync2_q;
   end

   // Two-flop synchroniser for the secondary mode pins; the code is a slow
   // level, so a torn sample while it changes lasts one cycle at most
   always_ff @(posedge mclk) begin
      if (rst) begin
         freqSync1_q <= 3'h0;
         freqSync2_q <= 3'h0;
      end else begin
         freqSync1_q <= secondaryFreqMode;
         freqSync2_q <= freqSync1_q;
      end
   end

   // Two-flop synchroniser and edge memory for the unexpected completion event
   always_ff @(posedge mclk) begin
      if (rst) begin
         unexpSync1_q <= 1'b0;
         unexpSync2_q <= 1'b0;
         unexpPrev_q <= 1'b0;
      end else begin
         unexpSync1_q <= unexpectedSplitCplEvent;
         unexpSync2_q <= unexpSync1_q;
         unexpPrev_q <= unexpSync2_q;
      end
   end

   // Two-flop synchroniser and edge memory for the aborted completion event
   always_ff @(posedge mclk) begin
      if (rst) begin
         abortSync1_q <= 1'b0;
         abortSync2_q <= 1'b0;
         abortPrev_q <= 1'b0;
      end else begin
         abortSync1_q <= splitCplAbortEvent;
         abortSync2_q <= abortSync1_q;
         abortPrev_q <= abortSync2_q;
      end
   end

   // Rising edges of synchronised events; the edge memories reset to the
   // idle low level of the pins, so no false edge follows reset
   assign unexpPulse = unexpSync2_q && !unexpPrev_q;
   assign abortPulse = abortSync2_q && !abortPrev_q;

   // Write data phase tracking; the address is kept so that the data
   // phase knows which register its word lands in
   always_ff @(posedge mclk) begin
      if (rst) begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 8'h00;
      end else begin
         if (hready) begin
            wrPend_q <= addrPhase && hwrite;
            wrAddr_q <= haddr[7:0];
         end
      end
   end

   // Next window register values; reserved low bits are never stored
   always_comb begin
      lowerBase_d = lowerBase_q;
      upperBase_d = upperBase_q;
      lowerLimit_d = lowerLimit_q;
      upperLimit_d = upperLimit_q;
      if (isWrite(OFS_SEC_LOWER_BASE)) begin
         lowerBase_d = hwdata[31:LOWER_ADDR_LSB];
      end
      if (isWrite(OFS_SEC_UPPER_BASE)) begin
         upperBase_d = hwdata;
      end
      if (isWrite(OFS_SEC_LOWER_LIMIT)) begin
         lowerLimit_d = hwdata[31:LOWER_ADDR_LSB];
      end
      if (isWrite(OFS_SEC_UPPER_LIMIT)) begin
         upperLimit_d = hwdata;
      end
   end

   // Next sticky flag values; an event wins over a write-one clear on one edge
   always_comb begin
      unexpectedSplitCpl_d = unexpectedSplitCpl_q;
      splitCplDiscarded_d = splitCplDiscarded_q;
      if (unexpPulse) begin
         unexpectedSplitCpl_d = 1'b1;
      end else if (isWrite(OFS_CAP_STATUS) && hwdata[UNEXPECTED_CPL_BIT]) begin
         unexpectedSplitCpl_d = 1'b0;
      end
      if (abortPulse) begin
         splitCplDiscarded_d = 1'b1;
      end else if (isWrite(OFS_CAP_STATUS) && hwdata[CPL_DISCARDED_BIT]) begin
         splitCplDiscarded_d = 1'b0;
      end
   end

   // Window base registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         lowerBase_q <= RESET_ZERO[31:20];
         upperBase_q <= RESET_ZERO;
      end else begin
         lowerBase_q <= lowerBase_d;
         upperBase_q <= upperBase_d;
      end
   end

   // Window limit registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         lowerLimit_q <= RESET_ZERO[31:20];
         upperLimit_q <= RESET_ZERO;
      end else begin
         lowerLimit_q <= lowerLimit_d;
         upperLimit_q <= upperLimit_d;
      end
   end

   // Unexpected split completion flag
   always_ff @(posedge mclk) begin
      if (rst) begin
         unexpectedSplitCpl_q <= 1'b0;
      end else begin
         unexpectedSplitCpl_q <= unexpectedSplitCpl_d;
      end
   end

   // Discarded split completion flag
   always_ff @(posedge mclk) begin
      if (rst) begin
         splitCplDiscarded_q <= 1'b0;
      end else begin
         splitCplDiscarded_q <= splitCplDiscarded_d;
      end
   end

   // Discard strobe to the completion path
   always_ff @(posedge mclk) begin
      if (rst) begin
         discard_q <= 1'b0;
      end else begin
         discard_q <= abortPulse;
      end
   end

   // Read data registered at the address phase
   always_ff @(posedge mclk) begin
      if (rst) begin
         hrdata_q <= RESET_ZERO;
      end else if (addrPhase && !hwrite) begin
         hrdata_q <= readMux(haddr[7:0], capStatus);
      end
   end

   // Full 64-bit window from register halves
   always_ff @(posedge mclk) begin
      if (rst) begin
         window_q <= '0;
      end else begin
         window_q.base <= {upperBase_q, lowerBase_q, LOW_BASE_FILL};
         window_q.limit <= {upperLimit_q, lowerLimit_q, LOW_LIMIT_FILL};
      end
   end

   // Fixed capability placement
   always_ff @(posedge mclk) begin
      if (rst) begin
         capabilityPointer <= 8'h00;
         firstExtCapOffset <= 12'h000;
      end else begin
         capabilityPointer <= FIRST_CAP_PTR;
         firstExtCapOffset <= FIRST_EXT_CAP_OFS;
      end
   end

   // Zero wait states, always OKAY
   always_ff @(posedge mclk) begin
      if (rst) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   assign hrdata = hrdata_q;
   assign secondaryWindow = window_q;
   assign splitCplDiscard = discard_q;
endmodule // nrc_regs
`default_nettype wire

//--- nrc_regs_asserts.sv
`default_nettype none
module nrc_regs_asserts
   import nrc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire nrc_pkg::nrc_window_s secondaryWindow,
   input wire logic splitCplDiscard,
   input wire logic [7:0] capabilityPointer,
   input wire logic [11:0] firstExtCapOffset
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic rdA;
   logic wrUb;
   // Address phase decode of reads and upper base writes
   assign rdA = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
   assign wrUb = hsel && hready && htrans == HTRANS_NONSEQ && hwrite && haddr[7:0] == 8'h74;
   cap_ptr_a: assert property (!$past(rst) |-> capabilityPointer == 8'h80) else $error("cap pointer");
   ext_cap_a: assert property (!$past(rst) |-> firstExtCapOffset == 12'h100) else $error("ext cap");
   limit_fill_a: assert property (!$past(rst) |-> secondaryWindow.limit[19:0] == 20'hFFFFF)
      else $error("limit fill");
   base_fill_a: assert property (secondaryWindow.base[19:0] == 20'h0) else $error("base fill");
   discard_pulse_a: assert property (splitCplDiscard |=> !splitCplDiscard) else $error("discard");
   cap_fixed_a: assert property (rdA && haddr[7:0] == 8'h80 |=> hrdata[15:0] == 16'hA007 &&
      hrdata[31:25] == 7'h0 && hrdata[21:20] == 2'h0) else $error("cap word");
   low_rsvd_a: assert property (rdA && haddr[7:0] inside {8'h70, 8'h78} |=> hrdata[19:0] == 20'h0)
      else $error("low reserved");
   upper_base_a: assert property (wrUb ##1 hready |=> ##1 secondaryWindow.base[63:32] == $past(hwdata, 2))
      else $error("upper base");
   // Main scenarios reached
   cover property (rdA && haddr[7:0] == 8'h80);
   cover property (splitCplDiscard);
   cover property (wrUb);
endmodule // nrc_regs_asserts
bind nrc_regs nrc_regs_asserts nrc_regs_asserts_i (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .secondaryWindow(secondaryWindow), .splitCplDiscard(splitCplDiscard),
   .capabilityPointer(capabilityPointer), .firstExtCapOffset(firstExtCapOffset));
`default_nettype wire

//--- nrc_regs_tb.sv
`default_nettype none
module nrc_regs_tb
   import nrc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = HTRANS_IDLE;
   logic hwrite = 1'b0;
   logic [2:0] freqMode = 3'h0;
   logic unexpEvt = 1'b0;
   logic abtEvt = 1'b0;
   logic [31:0] hrdata;
   logic [31:0] rv;
   logic hreadyout;
   logic hresp;
   logic discard;
   nrc_window_s win;
   logic [7:0] capPtr;
   logic [11:0] extOfs;
   int miscompares = 0;
   int compares = 0;
   // Clock of 25 ns
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   nrc_regs nrc_regs_i (.mclk(mclk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .secondaryFreqMode(freqMode), .unexpectedSplitCplEvent(unexpEvt), .splitCplAbortEvent(abtEvt),
      .secondaryWindow(win), .splitCplDiscard(discard), .capabilityPointer(capPtr), .firstExtCapOffset(extOfs));
   task print_verdict;
      if (miscompares == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task chk(input logic [127:0] got, input logic [127:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One AHB single transfer, read data kept in rv
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      haddr <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= HTRANS_IDLE;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask
   task rc(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rv, exp);
   endtask
   task t_reset;
      rc(8'h70, 32'h0);
      rc(8'h74, 32'h0);
      rc(8'h78, 32'h0);
      rc(8'h7C, 32'h0);
      rc(8'h80, 32'h0003A007);
      chk(capPtr, 8'h80);
      chk(extOfs, 12'h100);
   endtask
   task t_window;
      xfer(1'b1, 8'h70, 32'hFFFFFFFF);
      xfer(1'b1, 8'h74, 32'h12345678);
      xfer(1'b1, 8'h78, 32'hABCDE123);
      xfer(1'b1, 8'h7C, 32'h9ABCDEF0);
      rc(8'h70, 32'hFFF00000);
      rc(8'h74, 32'h12345678);
      rc(8'h78, 32'hABC00000);
      rc(8'h7C, 32'h9ABCDEF0);
      chk(win, {32'h12345678, 32'hFFF00000, 32'h9ABCDEF0, 32'hABCFFFFF});
      xfer(1'b1, 8'h90, 32'hFFFFFFFF);
      rc(8'h90, 32'h0);
      xfer(1'b1, 8'h80, 32'hFFFFFFFF);
      rc(8'h80, 32'h0003A007);
   endtask
   // Every documented mode code shows in the status word
   task t_freq;
      for (int i = 0; i < 4; i++) begin
         freqMode <= i[2:0];
         repeat (4) @(posedge mclk);
         rc(8'h80, 32'h0003A007 | (32'(i) << 22));
      end
      freqMode <= 3'h0;
   endtask
   // Split completion events set flags that software clears by writing one
   task t_event;
      logic hit;
      hit = 1'b0;
      unexpEvt <= 1'b1;
      repeat (2) @(posedge mclk);
      unexpEvt <= 1'b0;
      repeat (5) @(posedge mclk);
      rc(8'h80, 32'h000BA007);
      abtEvt <= 1'b1;
      repeat (8) begin
         @(posedge mclk);
         hit = hit | (discard === 1'b1);
      end
      abtEvt <= 1'b0;
      chk(hit, 1'b1);
      rc(8'h80, 32'h000FA007);
      xfer(1'b1, 8'h80, 32'h00080000);
      rc(8'h80, 32'h0007A007);
      xfer(1'b1, 8'h80, 32'h00040000);
      rc(8'h80, 32'h0003A007);
      // Event edge and write-one clear reach the flag on one edge: set wins
      unexpEvt <= 1'b1;
      xfer(1'b1, 8'h80, 32'h00080000);
      unexpEvt <= 1'b0;
      rc(8'h80, 32'h000BA007);
      xfer(1'b1, 8'h80, 32'h00080000);
      rc(8'h80, 32'h0003A007);
   endtask
   // Main sequence after a reset of three cycles
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      t_reset;
      t_window;
      t_freq;
      t_event;
      print_verdict;
   end
   // Watchdog against a hung transfer
   initial begin
      repeat (2000) @(posedge mclk);
      miscompares++;
      print_verdict;
   end
endmodule // nrc_regs_tb
`default_nettype wire
